// [rtl/srb_pkg.sv]
// Purpose: shared constants and carriers for the upper special register bank
// Assumes: 9-bit data-memory address, 8-bit data
// Notes: offsets are full data-memory addresses of bank 3
package srb_pkg;
	localparam logic [8:0] ADDR_INDIRECT_DATA_PORT = 9'h180;
	localparam logic [8:0] ADDR_OPTION_CONFIG = 9'h181;
	localparam logic [8:0] ADDR_PC_LOW_BYTE = 9'h182;
	localparam logic [8:0] ADDR_ALU_AND_RESET_FLAGS = 9'h183;
	localparam logic [8:0] ADDR_FILE_SELECT_POINTER = 9'h184;
	localparam logic [8:0] ADDR_PORT_B_DIRECTION = 9'h186;
	localparam logic [8:0] ADDR_PC_HIGH_LATCH = 9'h18a;
	localparam logic [8:0] ADDR_INTERRUPT_CONTROL = 9'h18b;
	localparam logic [8:0] BANK3_BASE = 9'h180;
	localparam logic [8:0] BANK3_LAST = 9'h19f;
	localparam int BIT_CARRY = 0;
	localparam int BIT_NIBBLE = 1;
	localparam int BIT_ZERO = 2;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_WDOG = 4;
	localparam int BIT_PAGE_LO = 5;
	localparam int BIT_PAGE_HI = 6;
	localparam int BIT_IND_PAGE = 7;
	localparam logic [7:0] RST_OPTION_CONFIG = 8'hff;
	localparam logic [7:0] RST_PC_LOW_BYTE = 8'h00;
	localparam logic [7:0] RST_ALU_AND_RESET_FLAGS = 8'h18;
	localparam logic [7:0] RST_FILE_SELECT_POINTER = 8'h00;
	localparam logic [7:0] RST_PORT_B_DIRECTION = 8'hff;
	localparam logic [4:0] RST_PC_HIGH_LATCH = 5'h00;
	localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;

	typedef enum logic [1:0] {ALU_NONE, ALU_ADD, ALU_SUB} srb_alu_op_t;

	// one data-memory access from the instruction datapath
	typedef struct packed {
		logic wrEn;
		logic [8:0] addr;
		logic [7:0] data;
		logic fileClear;
	} srb_access_t;

	// result flag update from the ALU
	typedef struct packed {
		srb_alu_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic zeroUpd;
	} srb_alu_t;
endpackage

// [rtl/srb_bank3.sv]
// Purpose: upper special register bank with the arithmetic and reset status register
// Assumes: one access per clock; read data is registered, one cycle after the request
// Notes: memory behind the indirect port sits outside; this block forms its address
//
// Overview of operation
// - status holds flags, reset cause, bank bits
// - any instruction may write status
// - flag-updating ops override written zero/carry bits
// - watchdog and sleep flags ignore writes
// - file clear: page bits zero, zero set
// - subtract drives carries as inverted borrow
// - unimplemented locations read zero
// - page bits decode into four banks
// - watchdog flag: clear on expiry, set on clear or sleep
// - sleep flag: clear on sleep, set on clear
// - nibble carry from bit3, carry from msb
`timescale 1ns/1ps
module srb_bank3 (
	input wire logic clk,
	input wire logic arst_n,
	input wire srb_pkg::srb_access_t acc,
	input wire srb_pkg::srb_alu_t alu,
	input wire logic wdogExpire,
	input wire logic wdogClearOp,
	input wire logic sleepOp,
	input wire logic [7:0] indRdData,
	output logic [7:0] rdData,
	output logic [8:0] indAddr,
	output logic indWrEn,
	output logic [7:0] indWrData,
	output logic [8:0] directBase,
	output logic [7:0] statusOut,
	output logic [7:0] optionOut,
	output logic [7:0] trisOut
);
	import srb_pkg::*;

	logic [7:0] statusReg_r;
	logic [7:0] optionReg_r;
	logic [7:0] pclReg_r;
	logic [7:0] fsrReg_r;
	logic [7:0] trisReg_r;
	logic [4:0] pclathReg_r;
	logic [7:0] intconReg_r;
	logic [7:0] statusReg_nxt;
	logic [8:0] sum;
	logic [4:0] nibbleSum;
	logic [7:0] result;
	logic hitStatus;
	logic hitIndirect;
	logic flagOp;

	assign hitStatus = acc.addr == ADDR_ALU_AND_RESET_FLAGS;
	assign hitIndirect = acc.addr == ADDR_INDIRECT_DATA_PORT;
	assign flagOp = alu.op != ALU_NONE || alu.zeroUpd;

	// subtraction adds the two's complement, so carries come out as not-borrow
	always_comb begin
		logic [7:0] bOp;
		bOp = (alu.op == ALU_SUB) ? ~alu.b : alu.b;
		sum = {1'b0, alu.a} + {1'b0, bOp} + {8'h00, alu.op == ALU_SUB};
		nibbleSum = {1'b0, alu.a[3:0]} + {1'b0, bOp[3:0]} + {4'h0, alu.op == ALU_SUB};
		result = sum[7:0];
	end

	always_comb begin
		statusReg_nxt = statusReg_r;
		if (acc.wrEn && hitStatus) begin
			// page bits follow the write
			statusReg_nxt[7:5] = acc.data[7:5];
			if (!flagOp)
				statusReg_nxt[2:0] = acc.data[2:0];
		end
		if (acc.fileClear && hitStatus) begin
			statusReg_nxt[7:5] = 3'h0;
			statusReg_nxt[BIT_ZERO] = 1'b1;
		end else if (alu.op != ALU_NONE) begin
			// alu result wins over the written value
			statusReg_nxt[BIT_CARRY] = sum[8];
			statusReg_nxt[BIT_NIBBLE] = nibbleSum[4];
			statusReg_nxt[BIT_ZERO] = result == 8'h00;
		end else if (alu.zeroUpd) begin
			statusReg_nxt[BIT_ZERO] = alu.a == 8'h00;
		end
		// reset-cause flags only move on hardware events
		if (wdogExpire)
			statusReg_nxt[BIT_WDOG] = 1'b0;
		else if (wdogClearOp || sleepOp)
			statusReg_nxt[BIT_WDOG] = 1'b1;
		if (sleepOp)
			statusReg_nxt[BIT_SLEEP] = 1'b0;
		else if (wdogClearOp)
			statusReg_nxt[BIT_SLEEP] = 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			statusReg_r <= RST_ALU_AND_RESET_FLAGS;
		else
			statusReg_r <= statusReg_nxt;
	end

	// plain read/write registers; fileClear zeroes them like a write of 0
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			optionReg_r <= RST_OPTION_CONFIG;
			pclReg_r <= RST_PC_LOW_BYTE;
			fsrReg_r <= RST_FILE_SELECT_POINTER;
			trisReg_r <= RST_PORT_B_DIRECTION;
			pclathReg_r <= RST_PC_HIGH_LATCH;
			intconReg_r <= RST_INTERRUPT_CONTROL;
		end else if (acc.wrEn || acc.fileClear) begin
			case (acc.addr)
				ADDR_OPTION_CONFIG: optionReg_r <= acc.fileClear ? 8'h00 : acc.data;
				ADDR_PC_LOW_BYTE: pclReg_r <= acc.fileClear ? 8'h00 : acc.data;
				ADDR_FILE_SELECT_POINTER: fsrReg_r <= acc.fileClear ? 8'h00 : acc.data;
				ADDR_PORT_B_DIRECTION: trisReg_r <= acc.fileClear ? 8'h00 : acc.data;
				ADDR_PC_HIGH_LATCH: pclathReg_r <= acc.fileClear ? 5'h00 : acc.data[4:0];
				ADDR_INTERRUPT_CONTROL: intconReg_r <= acc.fileClear ? 8'h00 : acc.data;
				default: ;
			endcase
		end
	end

	// indirect port: address from pointer plus page bit, no storage here
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			indAddr <= 9'h000;
			indWrEn <= 1'b0;
			indWrData <= 8'h00;
		end else begin
			indAddr <= {statusReg_nxt[BIT_IND_PAGE], fsrReg_r};
			indWrEn <= (acc.wrEn || acc.fileClear) && hitIndirect;
			indWrData <= acc.fileClear ? 8'h00 : acc.data;
		end
	end

	// read mux; indirect reads register the external memory byte unchanged, like the other entries
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= 8'h00;
		end else begin
			case (acc.addr)
				ADDR_INDIRECT_DATA_PORT: rdData <= indRdData;
				ADDR_OPTION_CONFIG: rdData <= optionReg_r;
				ADDR_PC_LOW_BYTE: rdData <= pclReg_r;
				ADDR_ALU_AND_RESET_FLAGS: rdData <= statusReg_r;
				ADDR_FILE_SELECT_POINTER: rdData <= fsrReg_r;
				ADDR_PORT_B_DIRECTION: rdData <= trisReg_r;
				ADDR_PC_HIGH_LATCH: rdData <= {3'h0, pclathReg_r};
				ADDR_INTERRUPT_CONTROL: rdData <= intconReg_r;
				default: rdData <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			directBase <= 9'h000;
			statusOut <= RST_ALU_AND_RESET_FLAGS;
			optionOut <= RST_OPTION_CONFIG;
			trisOut <= RST_PORT_B_DIRECTION;
		end else begin
			// bank = page bits: 0x000, 0x080, 0x100, 0x180
			directBase <= {statusReg_nxt[BIT_PAGE_HI:BIT_PAGE_LO], 7'h00};
			statusOut <= statusReg_nxt;
			optionOut <= (acc.wrEn && acc.addr == ADDR_OPTION_CONFIG) ? acc.data : optionReg_r;
			trisOut <= (acc.wrEn && acc.addr == ADDR_PORT_B_DIRECTION) ? acc.data : trisReg_r;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	logic clearStatus;
	assign clearStatus = acc.fileClear && hitStatus;

	// read side of the map
	unimpl_zero_a: assert property (acc.addr inside {9'h185, 9'h187, 9'h188, 9'h189}
		|=> rdData == 8'h00)
		else $error("unimplemented read not zero");

	unimpl_high_a: assert property (acc.addr > ADDR_INTERRUPT_CONTROL && acc.addr <= BANK3_LAST
		|=> rdData == 8'h00)
		else $error("upper unimplemented read not zero");

	pc_high_latch_upper_a: assert property (acc.addr == ADDR_PC_HIGH_LATCH
		|=> rdData[7:5] == 3'h0)
		else $error("latch upper bits not zero");

	rd_status_a: assert property (acc.addr == ADDR_ALU_AND_RESET_FLAGS
		|=> rdData == $past(statusReg_r))
		else $error("status read wrong");

	// software writes to status and option
	write_pages_a: assert property (acc.wrEn && hitStatus && !acc.fileClear
		|=> statusReg_r[7:5] == $past(acc.data[7:5]))
		else $error("page bits not written");

	write_low_a: assert property (acc.wrEn && hitStatus && !acc.fileClear && !flagOp
		|=> statusReg_r[2:0] == $past(acc.data[2:0]))
		else $error("flag bits not written");

	write_override_a: assert property (acc.wrEn && hitStatus && alu.op == ALU_ADD && !acc.fileClear
		|=> statusReg_r[BIT_CARRY] == (({1'b0, $past(alu.a)} + {1'b0, $past(alu.b)}) > 9'd255))
		else $error("alu did not override");

	option_write_a: assert property (acc.wrEn && acc.addr == ADDR_OPTION_CONFIG && !acc.fileClear
		|=> optionOut == $past(acc.data))
		else $error("option write lost");

	// zero flag from the operation result; reset flags held against writes
	add_zero_a: assert property (alu.op == ALU_ADD && !clearStatus
		|=> statusReg_r[BIT_ZERO] == (8'($past(alu.a) + $past(alu.b)) == 8'h00))
		else $error("add zero wrong");

	sub_zero_a: assert property (alu.op == ALU_SUB && !clearStatus
		|=> statusReg_r[BIT_ZERO] == ($past(alu.a) == $past(alu.b)))
		else $error("sub zero wrong");

	zero_only_a: assert property (alu.zeroUpd && alu.op == ALU_NONE && !clearStatus
		|=> statusReg_r[BIT_ZERO] == ($past(alu.a) == 8'h00))
		else $error("zero update wrong");

	flags_protect_a: assert property (acc.wrEn && hitStatus && !wdogExpire && !wdogClearOp && !sleepOp
		|=> statusReg_r[4:3] == $past(statusReg_r[4:3]))
		else $error("reset flags written");

	// clear of the status file
	clear_status_a: assert property (clearStatus
		|=> statusReg_r[7:5] == 3'h0 && statusReg_r[BIT_ZERO])
		else $error("file clear wrong");

	clear_keeps_a: assert property (clearStatus && !wdogExpire && !wdogClearOp && !sleepOp
		|=> statusReg_r[4:3] == $past(statusReg_r[4:3]) && statusReg_r[1:0] == $past(statusReg_r[1:0]))
		else $error("file clear touched other bits");

	// carries: borrow polarity on subtract, carry out on add; page bank decode
	sub_borrow_a: assert property (alu.op == ALU_SUB && !clearStatus
		|=> statusReg_r[BIT_CARRY] == ($past(alu.a) >= $past(alu.b)))
		else $error("borrow wrong");

	sub_nibble_a: assert property (alu.op == ALU_SUB && !clearStatus
		|=> statusReg_r[BIT_NIBBLE] == ($past(alu.a[3:0]) >= $past(alu.b[3:0])))
		else $error("nibble borrow wrong");

	add_nibble_a: assert property (alu.op == ALU_ADD && !clearStatus
		|=> statusReg_r[BIT_NIBBLE] == (({1'b0, $past(alu.a[3:0])} + {1'b0, $past(alu.b[3:0])}) > 5'd15))
		else $error("nibble carry wrong");

	add_msb_a: assert property (alu.op == ALU_ADD && !clearStatus
		|=> statusReg_r[BIT_CARRY] == (({1'b0, $past(alu.a)} + {1'b0, $past(alu.b)}) > 9'd255))
		else $error("carry wrong");

	page_decode_a: assert property (directBase == {statusReg_r[BIT_PAGE_HI:BIT_PAGE_LO], 7'h00}
		)
		else $error("bank decode wrong");

	// reset-cause flags
	wdog_expire_a: assert property (wdogExpire
		|=> !statusReg_r[BIT_WDOG])
		else $error("expiry not seen");

	wdog_set_a: assert property ((wdogClearOp || sleepOp) && !wdogExpire
		|=> statusReg_r[BIT_WDOG])
		else $error("watchdog flag not set");

	sleep_flag_a: assert property (sleepOp && !wdogExpire
		|=> !statusReg_r[BIT_SLEEP] && statusReg_r[BIT_WDOG])
		else $error("sleep flags wrong");

	sleep_clear_a: assert property (wdogClearOp && !sleepOp
		|=> statusReg_r[BIT_SLEEP])
		else $error("sleep flag not set");

	// indirect port
	ind_write_a: assert property (acc.wrEn && hitIndirect && !acc.fileClear
		|=> indWrEn && indWrData == $past(acc.data))
		else $error("indirect write lost");

	ind_quiet_a: assert property (!hitIndirect
		|=> !indWrEn)
		else $error("stray indirect write");

	ind_addr_a: assert property (indAddr == {statusReg_r[BIT_IND_PAGE], $past(fsrReg_r)}
		)
		else $error("indirect address wrong");

	ind_read_a: assert property (hitIndirect
		|=> rdData == $past(indRdData))
		else $error("indirect read wrong");

	status_write_c: cover property (acc.wrEn && hitStatus);
	sub_c: cover property (alu.op == ALU_SUB);
	clear_c: cover property (clearStatus);
	zero_upd_c: cover property (alu.zeroUpd && alu.op == ALU_NONE);
	ind_write_c: cover property (acc.wrEn && hitIndirect);
endmodule

// [dv/tb_srb_bank3.sv]
// Purpose: self-checking bench for the upper special register bank
// Assumes: read data one cycle after the access is taken
// Notes: reads are checked from a queue by a monitor
`timescale 1ns/1ps
module tb_srb_bank3;
	import srb_pkg::*;
	logic clk, arst_n, wdogExpire, wdogClearOp, sleepOp, indWrEn, rdIssue;
	logic rdPend = 1'b0;
	logic [7:0] indRdData, rdData, indWrData, statusOut, optionOut, trisOut;
	logic [8:0] indAddr, directBase, s;
	logic [4:0] n;
	logic [31:0] rng;
	srb_access_t acc;
	srb_alu_t alu;
	logic [7:0] expQ[$];
	int mismatches, num_checks, cycles;
	srb_bank3 uut (.clk(clk), .arst_n(arst_n), .acc(acc), .alu(alu), .wdogExpire(wdogExpire),
		.wdogClearOp(wdogClearOp), .sleepOp(sleepOp), .indRdData(indRdData), .rdData(rdData),
		.indAddr(indAddr), .indWrEn(indWrEn), .indWrData(indWrData), .directBase(directBase),
		.statusOut(statusOut), .optionOut(optionOut), .trisOut(trisOut));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// indirect read byte follows rng, which only changes when the test steps it
	task automatic cyc(input srb_access_t a, input srb_alu_t l, input logic [2:0] ev, input logic rd);
		@(posedge clk);
		acc <= a;
		alu <= l;
		{wdogExpire, wdogClearOp, sleepOp} <= ev;
		rdIssue <= rd;
		indRdData <= rng[31:24];
	endtask
	task automatic idle;
		cyc('0, '0, 3'b000, 1'b0);
		#1;
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		cyc('{1'b1, a, d, 1'b0}, '0, 3'b000, 1'b0);
		idle();
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		expQ.push_back(e);
		cyc('{1'b0, a, 8'h00, 1'b0}, '0, 3'b000, 1'b1);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			stop_test();
		end
		if (rdPend)
			chk("rdData", {1'b0, rdData}, {1'b0, expQ.pop_front()});
		rdPend <= rdIssue;
	end
	initial begin
		{arst_n, wdogExpire, wdogClearOp, sleepOp, rdIssue} = '0;
		acc = '0;
		alu = '0;
		indRdData = 8'h00;
		rng = 32'd89690;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		wr(9'h185, 8'haa);
		rd(ADDR_OPTION_CONFIG, 8'hff);
		rd(ADDR_PC_LOW_BYTE, 8'h00);
		rd(ADDR_ALU_AND_RESET_FLAGS, 8'h18);
		rd(ADDR_FILE_SELECT_POINTER, 8'h00);
		rd(9'h185, 8'h00);
		rd(ADDR_PORT_B_DIRECTION, 8'hff);
		rd(ADDR_PC_HIGH_LATCH, 8'h00);
		rd(ADDR_INTERRUPT_CONTROL, 8'h00);
		rd(BANK3_LAST, 8'h00);
		idle();
		idle();
		$display("test reset map done");
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_ALU_AND_RESET_FLAGS, {1'b0, 2'(p), 5'h00});
			chk("statusOut", {1'b0, statusOut}, {2'b00, 2'(p), 5'h18});
			chk("directBase", directBase, {2'(p), 7'h00});
		end
		wr(ADDR_ALU_AND_RESET_FLAGS, 8'he7);
		chk("statusOut", {1'b0, statusOut}, 9'h0ff);
		cyc('{1'b0, ADDR_ALU_AND_RESET_FLAGS, 8'h55, 1'b1}, '0, 3'b000, 1'b0);
		idle();
		chk("statusOut", {1'b0, statusOut}, 9'h01f);
		cyc('{1'b1, ADDR_ALU_AND_RESET_FLAGS, 8'he7, 1'b0}, '{ALU_ADD, 8'h0f, 8'h01, 1'b0}, 3'b000, 1'b0);
		idle();
		chk("statusOut", {1'b0, statusOut}, 9'h0fa);
		$display("test status writes done");
		// expected flags: carry out on add, not-borrow on subtract
		for (int i = 0; i < 24; i++) begin
			rng = xs(rng);
			cyc('0, '{rng[16] ? ALU_SUB : ALU_ADD, rng[7:0], rng[15:8], 1'b0}, 3'b000, 1'b0);
			idle();
			s = {1'b0, rng[7:0]} + {1'b0, rng[15:8]};
			n = {1'b0, rng[3:0]} + {1'b0, rng[11:8]};
			chk("flags", {6'h00, statusOut[2:0]}, rng[16] ? {6'h00, rng[7:0] == rng[15:8], rng[3:0] >= rng[11:8],
				rng[7:0] >= rng[15:8]} : {6'h00, s[7:0] == 8'h00, n[4], s[8]});
		end
		$display("test alu flags done");
		cyc('0, '0, 3'b100, 1'b0);
		idle();
		chk("resetFlags", {7'h00, statusOut[4:3]}, 9'h001);
		cyc('0, '0, 3'b001, 1'b0);
		idle();
		chk("resetFlags", {7'h00, statusOut[4:3]}, 9'h002);
		cyc('0, '0, 3'b010, 1'b0);
		idle();
		chk("resetFlags", {7'h00, statusOut[4:3]}, 9'h003);
		cyc('{1'b1, ADDR_ALU_AND_RESET_FLAGS, 8'h00, 1'b0}, '{ALU_NONE, 8'h00, 8'h00, 1'b1}, 3'b000, 1'b0);
		idle();
		chk("zeroFlag", {5'h00, statusOut[7:5], statusOut[2]}, 9'h001);
		$display("test reset flags done");
		wr(ADDR_FILE_SELECT_POINTER, 8'h55);
		wr(ADDR_ALU_AND_RESET_FLAGS, 8'h80);
		cyc('{1'b1, ADDR_INDIRECT_DATA_PORT, 8'h3c, 1'b0}, '0, 3'b000, 1'b0);
		idle();
		chk("indWrEn", {8'h00, indWrEn}, 9'h001);
		chk("indAddr", indAddr, 9'h155);
		chk("indWrData", {1'b0, indWrData}, 9'h03c);
		rng = xs(rng);
		rd(ADDR_INDIRECT_DATA_PORT, rng[31:24]);
		wr(ADDR_OPTION_CONFIG, rng[7:0]);
		wr(ADDR_PORT_B_DIRECTION, rng[15:8]);
		chk("optionOut", {1'b0, optionOut}, {1'b0, rng[7:0]});
		chk("trisOut", {1'b0, trisOut}, {1'b0, rng[15:8]});
		idle();
		$display("test indirect done");
		@(posedge clk);
		arst_n <= 1'b0;
		#5;
		chk("statusOut", {1'b0, statusOut}, 9'h018);
		chk("optionOut", {1'b0, optionOut}, 9'h0ff);
		chk("trisOut", {1'b0, trisOut}, 9'h0ff);
		$display("test second reset done");
		stop_test();
	end
endmodule
